// File: rtl/hwpa_pkg.sv
// Shared constants for the host word-pair assembler.
// Assumes a single system clock and a synchronous active-high reset.
package hwpa_pkg;
    localparam int          HWPA_ADDR_W       = 7;   // Host address bits A[7:1]
    localparam int          HWPA_IDX_W        = 6;   // Word index, A[7:2]
    localparam int          HWPA_HALF_POS     = 0;   // Position of the half-select bit
    localparam logic [5:0]  HWPA_IDX_WORD_ORD = 6'h3e;
    localparam logic [5:0]  HWPA_IDX_TX_FIFO  = 6'h08;
    localparam logic [5:0]  HWPA_IDX_RX_FIFO  = 6'h00;
    localparam logic [31:0] HWPA_WORD_ORD_RST = 32'h0000_0000;
    localparam logic [31:0] HWPA_SWAP_CODE    = 32'hffff_ffff;
    localparam int          HWPA_SYNC_W       = 27;  // cs, rd, wr, mode, addr, data

    typedef enum logic [1:0] {
        HWPA_RD_IDLE  = 2'b01,
        HWPA_RD_FETCH = 2'b10
    } hwpa_rd_state_t;
endpackage : hwpa_pkg

// File: rtl/hwpa_half_stream.sv
// Splits committed transmit words into halves and joins received halves.
// Assumes pushes are spaced by at least two cycles, which the host port guarantees.
`timescale 1ns/1ps
module hwpa_half_stream (
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    input  wire logic        tx_push_in,
    input  wire logic [31:0] tx_word_in,
    output logic             net_tx_valid_out,
    output logic [15:0]      net_tx_half_out,
    input  wire logic        net_rx_valid_in,
    input  wire logic [15:0] net_rx_half_in,
    output logic [31:0]      rx_word_out
);
    import hwpa_pkg::*;

    logic [15:0] tx_hi_r;
    logic        tx_second_r;
    logic [15:0] rx_lo_r;
    logic        rx_got_lo_r;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            net_tx_valid_out <= 1'b0;
            net_tx_half_out  <= 16'h0000;
            tx_hi_r          <= 16'h0000;
            tx_second_r      <= 1'b0;
        end else if (tx_push_in) begin
            net_tx_valid_out <= 1'b1;
            net_tx_half_out  <= tx_word_in[15:0];
            tx_hi_r          <= tx_word_in[31:16];
            tx_second_r      <= 1'b1;
        end else if (tx_second_r) begin
            net_tx_half_out  <= tx_hi_r;
            tx_second_r      <= 1'b0;
        end else begin
            net_tx_valid_out <= 1'b0;
        end
    end

    // Received stream fills the low half first
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rx_lo_r     <= 16'h0000;
            rx_got_lo_r <= 1'b0;
            rx_word_out <= 32'h0000_0000;
        end else if (net_rx_valid_in) begin
            if (!rx_got_lo_r) begin
                rx_lo_r     <= net_rx_half_in;
                rx_got_lo_r <= 1'b1;
            end else begin
                rx_word_out <= {net_rx_half_in, rx_lo_r};
                rx_got_lo_r <= 1'b0;
            end
        end
    end
endmodule : hwpa_half_stream

// File: rtl/hwpa_assembler.sv
// Host 16-bit port that pairs halves into 32-bit internal words.
// Assumes host strobes are asynchronous and held for at least six clocks.
// Summary of operation
// - Either half may come first if the next access hits the other half.
// - A repeated same-half write is discarded; target stays unchanged.
// - A repeated same-half read clears read pairing; next read starts anew.
// - Swapped mapping only when word order setting is all ones.
// - Default: half bit low gives bytes 1:0, high gives bytes 3:2.
// - Swapped: half bit low gives bytes 3:2, high gives bytes 1:0.
// - Mapping applies alike to registers and transmit/receive FIFO words.
// - Low internal half goes to network first and is received first.
// - Word order selection acts only in 16-bit bus mode.
`timescale 1ns/1ps
module hwpa_assembler (
    input  wire logic                         clk_sys_in,
    input  wire logic                         reset_in,
    input  wire logic                         host_cs_n_in,
    input  wire logic                         host_rd_n_in,
    input  wire logic                         host_wr_n_in,
    input  wire logic                         bus16_mode_in,
    input  wire logic [hwpa_pkg::HWPA_ADDR_W-1:0] host_addr_in,
    input  wire logic [15:0]                  host_data_in,
    output logic [15:0]                       host_data_out,
    output logic                              host_data_oe_out,
    output logic                              csr_wr_en_out,
    output logic [hwpa_pkg::HWPA_IDX_W-1:0]   csr_wr_idx_out,
    output logic [31:0]                       csr_wr_data_out,
    output logic                              csr_rd_en_out,
    output logic [hwpa_pkg::HWPA_IDX_W-1:0]   csr_rd_idx_out,
    input  wire logic [31:0]                  csr_rd_data_in,
    output logic                              word_swap_active_out,
    output logic                              net_tx_valid_out,
    output logic [15:0]                       net_tx_half_out,
    input  wire logic                         net_rx_valid_in,
    input  wire logic [15:0]                  net_rx_half_in
);
    import hwpa_pkg::*;

    logic [HWPA_SYNC_W-1:0] sync1_r;
    logic [HWPA_SYNC_W-1:0] sync2_r;
    logic                   rd_act_d_r;
    logic                   wr_act_d_r;
    logic [HWPA_ADDR_W-1:0] wr_lat_addr_r;
    logic [15:0]            wr_lat_data_r;
    logic [31:0]            word_order_r;
    logic                   wr_pend_r;
    logic                   wr_half_r;
    logic [HWPA_IDX_W-1:0]  wr_idx_r;
    logic [15:0]            wr_hold_r;
    logic                   tx_push_r;
    logic                   rd_pend_r;
    logic                   rd_half_r;
    logic [HWPA_IDX_W-1:0]  rd_idx_r;
    logic [31:0]            rd_word_r;
    hwpa_rd_state_t         rd_state_r;
    logic [31:0]            rx_word;

    logic                  s_cs_n, s_rd_n, s_wr_n, s_bus16;
    logic [HWPA_ADDR_W-1:0] s_addr;
    logic                  rd_act, wr_act, rd_evt, wr_evt, swap;
    logic                  wr_h, rd_h, wr_match, rd_match, wr_commit, wr_drop;
    logic [HWPA_IDX_W-1:0] wr_idx, rd_idx;
    logic [31:0]           full_word, rd_src;
    logic [15:0]           rd_second_half, fetch_half, commit_lo, commit_hi;

    // Pins are asynchronous to the clock; only the second stage is read
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            sync1_r <= '1;
            sync2_r <= '1;
        end else begin
            sync1_r <= {host_cs_n_in, host_rd_n_in, host_wr_n_in, bus16_mode_in,
                        host_addr_in, host_data_in};
            sync2_r <= sync1_r;
        end
    end

    assign {s_cs_n, s_rd_n, s_wr_n, s_bus16, s_addr} = sync2_r[HWPA_SYNC_W-1:16];
    assign rd_act = !s_cs_n && !s_rd_n;
    assign wr_act = !s_cs_n && !s_wr_n;
    assign rd_evt = rd_act && !rd_act_d_r;
    // Write data taken at strobe end, when the host has surely settled it
    assign wr_evt = !wr_act && wr_act_d_r;
    assign swap   = s_bus16 && (word_order_r == HWPA_SWAP_CODE);

    // Internal half = half-select bit, inverted under swap
    assign wr_idx    = wr_lat_addr_r[HWPA_ADDR_W-1:1];
    assign rd_idx    = s_addr[HWPA_ADDR_W-1:1];
    assign wr_h      = wr_lat_addr_r[HWPA_HALF_POS] ^ swap;
    assign rd_h      = s_addr[HWPA_HALF_POS] ^ swap;
    assign wr_match  = wr_pend_r && (wr_idx == wr_idx_r);
    assign rd_match  = rd_pend_r && (rd_idx == rd_idx_r);
    assign wr_commit = wr_evt && wr_match && (wr_h != wr_half_r);
    assign wr_drop   = wr_evt && wr_match && (wr_h == wr_half_r);
    assign full_word = wr_h ? {wr_lat_data_r, wr_hold_r} : {wr_hold_r, wr_lat_data_r};
    assign rd_second_half = rd_h ? rd_word_r[31:16] : rd_word_r[15:0];
    assign rd_src = (rd_idx_r == HWPA_IDX_WORD_ORD) ? word_order_r :
                    (rd_idx_r == HWPA_IDX_RX_FIFO)  ? rx_word : csr_rd_data_in;
    assign fetch_half = rd_half_r ? rd_src[31:16] : rd_src[15:0];
    assign commit_lo  = csr_wr_data_out[15:0];
    assign commit_hi  = csr_wr_data_out[31:16];

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rd_act_d_r       <= 1'b0;
            wr_act_d_r       <= 1'b0;
            wr_lat_addr_r    <= '0;
            wr_lat_data_r    <= 16'h0000;
            host_data_oe_out <= 1'b0;
            word_swap_active_out <= 1'b0;
        end else begin
            rd_act_d_r       <= rd_act;
            wr_act_d_r       <= wr_act;
            host_data_oe_out <= rd_act;
            word_swap_active_out <= swap;
            if (wr_act) begin
                wr_lat_addr_r <= s_addr;
                wr_lat_data_r <= sync2_r[15:0];
            end
        end
    end

    // Write pairing
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            wr_pend_r <= 1'b0;
            wr_half_r <= 1'b0;
            wr_idx_r  <= '0;
            wr_hold_r <= 16'h0000;
        end else if (wr_commit || wr_drop) begin
            wr_pend_r <= 1'b0;
        end else if (wr_evt) begin
            wr_pend_r <= 1'b1;
            wr_half_r <= wr_h;
            wr_idx_r  <= wr_idx;
            wr_hold_r <= wr_lat_data_r;
        end
    end

    // Whole word lands in one cycle, never half-updated
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            csr_wr_en_out   <= 1'b0;
            csr_wr_idx_out  <= '0;
            csr_wr_data_out <= 32'h0000_0000;
            tx_push_r       <= 1'b0;
            word_order_r    <= HWPA_WORD_ORD_RST;
        end else begin
            csr_wr_en_out <= wr_commit && (wr_idx != HWPA_IDX_WORD_ORD)
                             && (wr_idx != HWPA_IDX_TX_FIFO);
            tx_push_r     <= wr_commit && (wr_idx == HWPA_IDX_TX_FIFO);
            if (wr_commit) begin
                csr_wr_idx_out  <= wr_idx;
                csr_wr_data_out <= full_word;
                if (wr_idx == HWPA_IDX_WORD_ORD)
                    word_order_r <= full_word;
            end
        end
    end

    // Read pairing and fetch
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rd_pend_r      <= 1'b0;
            rd_half_r      <= 1'b0;
            rd_idx_r       <= '0;
            rd_word_r      <= 32'h0000_0000;
            rd_state_r     <= HWPA_RD_IDLE;
            csr_rd_en_out  <= 1'b0;
            csr_rd_idx_out <= '0;
            host_data_out  <= 16'h0000;
        end else begin
            csr_rd_en_out <= 1'b0;
            case (rd_state_r)
                HWPA_RD_IDLE: begin
                    if (rd_evt && rd_match) begin
                        // Repeat returns stale half; host must reread
                        host_data_out <= rd_second_half;
                        rd_pend_r     <= 1'b0;
                    end else if (rd_evt) begin
                        rd_pend_r      <= 1'b1;
                        rd_half_r      <= rd_h;
                        rd_idx_r       <= rd_idx;
                        csr_rd_idx_out <= rd_idx;
                        csr_rd_en_out  <= (rd_idx != HWPA_IDX_WORD_ORD);
                        rd_state_r     <= HWPA_RD_FETCH;
                    end
                end
                HWPA_RD_FETCH: begin
                    rd_word_r     <= rd_src;
                    host_data_out <= fetch_half;
                    rd_state_r    <= HWPA_RD_IDLE;
                end
                default: rd_state_r <= HWPA_RD_IDLE;
            endcase
        end
    end

    hwpa_half_stream u_stream (
        .clk_sys_in       (clk_sys_in),
        .reset_in         (reset_in),
        .tx_push_in       (tx_push_r),
        .tx_word_in       (csr_wr_data_out),
        .net_tx_valid_out (net_tx_valid_out),
        .net_tx_half_out  (net_tx_half_out),
        .net_rx_valid_in  (net_rx_valid_in),
        .net_rx_half_in   (net_rx_half_in),
        .rx_word_out      (rx_word)
    );

    property p_commit;
        @(posedge clk_sys_in) disable iff (reset_in)
        wr_commit |=> csr_wr_data_out == $past(full_word) ##1 !csr_wr_en_out;
    endproperty
    a_commit: assert property (p_commit) else $error("paired write not committed");

    property p_drop;
        @(posedge clk_sys_in) disable iff (reset_in)
        wr_drop |=> !csr_wr_en_out && !tx_push_r && $stable(word_order_r) && !wr_pend_r;
    endproperty
    a_drop: assert property (p_drop) else $error("repeated write not dropped");

    property p_swap_code;
        @(posedge clk_sys_in) disable iff (reset_in)
        word_swap_active_out |-> $past(word_order_r) == HWPA_SWAP_CODE;
    endproperty
    a_swap_code: assert property (p_swap_code) else $error("swap without all ones");

    property p_swap_mode;
        @(posedge clk_sys_in) disable iff (reset_in)
        !s_bus16 |=> !word_swap_active_out;
    endproperty
    a_swap_mode: assert property (p_swap_mode) else $error("swap outside 16-bit mode");

    property p_rd_repeat;
        @(posedge clk_sys_in) disable iff (reset_in)
        (rd_evt && rd_match && rd_h == rd_half_r) |=> !rd_pend_r && !csr_rd_en_out;
    endproperty
    a_rd_repeat: assert property (p_rd_repeat) else $error("read pairing not cleared");

    property p_rd_second;
        @(posedge clk_sys_in) disable iff (reset_in)
        (rd_evt && rd_match && rd_h != rd_half_r)
            |=> host_data_out == $past(rd_second_half) && rd_state_r == HWPA_RD_IDLE;
    endproperty
    a_rd_second: assert property (p_rd_second) else $error("second half wrong");

    property p_fetch;
        @(posedge clk_sys_in) disable iff (reset_in)
        (rd_evt && !rd_match) |=> ##1 host_data_out == $past(fetch_half) && rd_pend_r;
    endproperty
    a_fetch: assert property (p_fetch) else $error("first half mapping wrong");

    property p_tx_order;
        @(posedge clk_sys_in) disable iff (reset_in)
        tx_push_r |=> net_tx_valid_out && net_tx_half_out == $past(commit_lo)
            ##1 net_tx_valid_out && net_tx_half_out == $past(commit_hi, 2);
    endproperty
    a_tx_order: assert property (p_tx_order) else $error("tx half order wrong");

    c_commit:  cover property (@(posedge clk_sys_in) disable iff (reset_in) wr_commit);
    c_drop:    cover property (@(posedge clk_sys_in) disable iff (reset_in) wr_drop);
    c_swapped: cover property (@(posedge clk_sys_in) disable iff (reset_in)
                               word_swap_active_out && tx_push_r);
    c_rd_rep:  cover property (@(posedge clk_sys_in) disable iff (reset_in)
                               rd_evt && rd_match && rd_h == rd_half_r);
endmodule : hwpa_assembler

// File: tb/hwpa_host_model.sv
// Host processor model: drives the 16-bit port with whole half accesses.
// Assumes the port synchronises strobes, address and data before use.
`timescale 1ns/1ps
module hwpa_host_model (
    input  wire logic        clk_sys_in,
    output logic             host_cs_n_out,
    output logic             host_rd_n_out,
    output logic             host_wr_n_out,
    output logic [6:0]       host_addr_out,
    output logic [15:0]      host_data_out,
    input  wire logic [15:0] host_rdata_in
);
    // Strobe length covers the four-clock pin-to-data latency
    localparam int STROBE_CYC = 8;
    localparam int GAP_CYC    = 6;

    initial begin
        host_cs_n_out = 1'b1;
        host_rd_n_out = 1'b1;
        host_wr_n_out = 1'b1;
        host_addr_out = 7'h00;
        host_data_out = 16'h0000;
    end

    task automatic access(input logic [5:0] idx, input logic half, input logic is_wr,
                          input logic [15:0] wdata, output logic [15:0] rdata);
        @(posedge clk_sys_in);
        #1;
        host_addr_out = {idx, half};
        host_data_out = wdata;
        host_cs_n_out = 1'b0;
        host_wr_n_out = !is_wr;
        host_rd_n_out = is_wr;
        repeat (STROBE_CYC) @(posedge clk_sys_in);
        rdata = host_rdata_in;
        #1;
        host_cs_n_out = 1'b1;
        host_rd_n_out = 1'b1;
        host_wr_n_out = 1'b1;
        // Released bus must not keep showing the written value
        host_data_out = ~wdata;
        repeat (GAP_CYC) @(posedge clk_sys_in);
    endtask : access
endmodule : hwpa_host_model

// File: tb/tb.sv
// Self-checking bench for the host word-pair assembler.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps
module tb;
    import hwpa_pkg::*;
    logic        clk_sys_in, reset_in, bus16_mode_in, cs_n, rd_n, wr_n, oe;
    logic        csr_wr_en, csr_rd_en, swap_act, tx_v, rx_v;
    logic [6:0]  addr;
    logic [5:0]  wr_idx, rd_idx;
    logic [15:0] wdata, rdata, tx_h, rx_h, r;
    logic [31:0] wr_word, rd_word, n, m;
    logic [31:0] mem [0:63];
    logic [15:0] tx_q [$];
    int          fails, checked, cyc, wr_cnt, rd_cnt, oe_cnt;

    hwpa_host_model i_host (.clk_sys_in(clk_sys_in), .host_cs_n_out(cs_n),
        .host_rd_n_out(rd_n), .host_wr_n_out(wr_n), .host_addr_out(addr),
        .host_data_out(wdata), .host_rdata_in(rdata));

    hwpa_assembler i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .host_cs_n_in(cs_n), .host_rd_n_in(rd_n), .host_wr_n_in(wr_n),
        .bus16_mode_in(bus16_mode_in), .host_addr_in(addr), .host_data_in(wdata),
        .host_data_out(rdata), .host_data_oe_out(oe), .csr_wr_en_out(csr_wr_en),
        .csr_wr_idx_out(wr_idx), .csr_wr_data_out(wr_word), .csr_rd_en_out(csr_rd_en),
        .csr_rd_idx_out(rd_idx), .csr_rd_data_in(rd_word),
        .word_swap_active_out(swap_act), .net_tx_valid_out(tx_v),
        .net_tx_half_out(tx_h), .net_rx_valid_in(rx_v), .net_rx_half_in(rx_h));

    assign rd_word = mem[rd_idx];

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    always @(posedge clk_sys_in) begin
        cyc = cyc + 1;
        if (csr_wr_en === 1'b1) begin
            mem[wr_idx] <= wr_word;
            wr_cnt = wr_cnt + 1;
        end
        if (tx_v === 1'b1)
            tx_q.push_back(tx_h);
        if (csr_rd_en === 1'b1)
            rd_cnt = rd_cnt + 1;
        if (oe === 1'b1)
            oe_cnt = oe_cnt + 1;
        if (cyc == 5000) begin
            fails = fails + 1;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [5:0] idx, input logic half, input logic [15:0] d);
        i_host.access(idx, half, 1'b1, d, r);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic half, input logic [15:0] exp);
        i_host.access(idx, half, 1'b0, 16'h0000, r);
        check("read half", {16'h0000, r}, {16'h0000, exp});
    endtask : rd

    task automatic tx_chk(input logic [15:0] first, input logic [15:0] second);
        // High half lands in the queue on the edge the write task returns at
        repeat (2) @(posedge clk_sys_in);
        #1;
        check("tx count", 32'(tx_q.size()), 32'h0000_0002);
        check("tx first", {16'h0000, tx_q[0]}, {16'h0000, first});
        check("tx second", {16'h0000, tx_q[1]}, {16'h0000, second});
        tx_q.delete();
    endtask : tx_chk

    task automatic rx_word(input logic [15:0] lo, input logic [15:0] hi);
        @(posedge clk_sys_in);
        #1 rx_v = 1'b1;
        rx_h = lo;
        @(posedge clk_sys_in);
        #1 rx_h = hi;
        @(posedge clk_sys_in);
        #1 rx_v = 1'b0;
        rx_h = ~hi;
    endtask : rx_word

    task automatic set_mode(input logic m);
        @(posedge clk_sys_in);
        #1 bus16_mode_in = m;
        repeat (8) @(posedge clk_sys_in);
    endtask : set_mode

    task automatic finish_test();
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    initial begin
        fails = 0; checked = 0; cyc = 0; wr_cnt = 0; rd_cnt = 0; oe_cnt = 0;
        for (int i = 0; i < 64; i++)
            mem[i] = 32'h0000_0000;
        reset_in = 1'b1; bus16_mode_in = 1'b1; rx_v = 1'b0; rx_h = 16'h0000;
        repeat (20) @(posedge clk_sys_in);
        #1 reset_in = 1'b0;
        check("swap after reset", {31'h0, swap_act}, 32'h0000_0000);
        check("oe idle", {31'h0, oe}, 32'h0000_0000);
        wr(6'h05, 1'b0, 16'h1111); wr(6'h05, 1'b1, 16'h2222);
        check("pair low first", mem[5], 32'h2222_1111);
        wr(6'h06, 1'b1, 16'hbbbb); wr(6'h06, 1'b0, 16'haaaa);
        check("pair high first", mem[6], 32'hbbbb_aaaa);
        n = 32'(wr_cnt);
        wr(6'h07, 1'b0, 16'hcccc); wr(6'h07, 1'b0, 16'hdddd);
        check("repeat write target", mem[7], 32'h0000_0000);
        check("repeat write commits", 32'(wr_cnt), n);
        wr(6'h07, 1'b1, 16'heeee); wr(6'h07, 1'b0, 16'hffff);
        check("pair after drop", mem[7], 32'heeee_ffff);
        rd(6'h05, 1'b0, 16'h1111); rd(6'h05, 1'b1, 16'h2222);
        // Second same-half read is invalid and clears read pairing
        i_host.access(6'h05, 1'b1, 1'b0, 16'h0000, r);
        i_host.access(6'h05, 1'b1, 1'b0, 16'h0000, r);
        rd(6'h05, 1'b1, 16'h2222); rd(6'h05, 1'b0, 16'h1111);
        wr(HWPA_IDX_TX_FIFO, 1'b0, 16'h7777); wr(HWPA_IDX_TX_FIFO, 1'b1, 16'h8888);
        tx_chk(16'h7777, 16'h8888);
        rx_word(16'h5555, 16'h6666);
        rd(HWPA_IDX_RX_FIFO, 1'b0, 16'h5555); rd(HWPA_IDX_RX_FIFO, 1'b1, 16'h6666);
        wr(HWPA_IDX_WORD_ORD, 1'b0, 16'hffff); wr(HWPA_IDX_WORD_ORD, 1'b1, 16'hffff);
        check("swap on", {31'h0, swap_act}, 32'h0000_0001);
        rd(6'h05, 1'b0, 16'h2222); rd(6'h05, 1'b1, 16'h1111);
        wr(6'h09, 1'b0, 16'h1234); wr(6'h09, 1'b1, 16'h5678);
        check("swapped write", mem[9], 32'h1234_5678);
        wr(HWPA_IDX_TX_FIFO, 1'b1, 16'h3333); wr(HWPA_IDX_TX_FIFO, 1'b0, 16'h4444);
        tx_chk(16'h3333, 16'h4444);
        rx_word(16'h9999, 16'h7777);
        rd(HWPA_IDX_RX_FIFO, 1'b1, 16'h9999); rd(HWPA_IDX_RX_FIFO, 1'b0, 16'h7777);
        set_mode(1'b0);
        check("swap in 32-bit mode", {31'h0, swap_act}, 32'h0000_0000);
        rd(6'h05, 1'b0, 16'h1111); rd(6'h05, 1'b1, 16'h2222);
        wr(HWPA_IDX_WORD_ORD, 1'b0, 16'hfffe); wr(HWPA_IDX_WORD_ORD, 1'b1, 16'hffff);
        set_mode(1'b1);
        check("swap not all ones", {31'h0, swap_act}, 32'h0000_0000);
        n = 32'(rd_cnt);
        m = 32'(oe_cnt);
        rd(6'h05, 1'b0, 16'h1111); rd(6'h05, 1'b1, 16'h2222);
        // Only the first half of a pair fetches a word
        check("csr read pulses", 32'(rd_cnt), n + 32'h0000_0001);
        // Two strobes of eight cycles each
        check("oe cycles", 32'(oe_cnt), m + 32'h0000_0010);
        n = 32'(rd_cnt);
        rd(HWPA_IDX_WORD_ORD, 1'b0, 16'hfffe); rd(HWPA_IDX_WORD_ORD, 1'b1, 16'hffff);
        check("word order read pulses", 32'(rd_cnt), n);
        wr(HWPA_IDX_WORD_ORD, 1'b0, 16'hffff); wr(HWPA_IDX_WORD_ORD, 1'b1, 16'hffff);
        check("swap before reset", {31'h0, swap_act}, 32'h0000_0001);
        @(posedge clk_sys_in);
        #1 reset_in = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1 reset_in = 1'b0;
        check("swap after mid reset", {31'h0, swap_act}, 32'h0000_0000);
        rd(HWPA_IDX_WORD_ORD, 1'b0, 16'h0000); rd(HWPA_IDX_WORD_ORD, 1'b1, 16'h0000);
        finish_test();
    end
endmodule : tb
